//--- design/aicas_top.sv
// Functional notes
// - Power code 00: deep sleep, analogue supply and gate drivers off.
// - Power code 01: sleep, digital side kept running; code 11 returns to play.
// - Power code 10: only output legs high impedance; code 11 resumes play.
// - Power code 11: play, output legs actively switching.
// - Three modulation schemes selected by bits 1:0 of modulation_control.
// - Both-side: legs in phase at zero, duties split around 50 percent.
// - Single-side: idle near 14 percent, falling leg rails, rising leg modulates.
// - Hybrid: signal level versus supply setting picks the duty scheme.
// - Two-wire slave at 100/400 kHz, single and sequential writes and reads.
// - Register 0 of any page selects the page, values 0 to 255.
// - Seven-bit slave address, upper five bits 01011.
// - Low two address bits come from the strap stage on the first link clock after reset, which still holds 00.
// - Single write: address, register byte, data byte, each acknowledged.
// - Sequential write acknowledges each byte then increments register address.
// - Single read: register write, repeated start, one byte, master nack.
// - Sequential read returns consecutive registers until master nack.
// - On page zero, register 0x7F selects the book.
// - Writing zero to modulation_control selects both-side modulation.
module aicas_top
  import aicas_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_link_clock,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic [1:0] i_addr_strap,
  input  wire logic [7:0] i_sample,
  input  wire logic [7:0] i_supply_level,
  output logic            o_analog_supply_en,
  output logic            o_gate_drive_en,
  output logic            o_output_hiz,
  output logic            o_positive_output_leg,
  output logic            o_negative_output_leg
);

  // ----------------------------------------------------------------
  // Link domain: pin synchronisers and strap capture
  // ----------------------------------------------------------------
  logic [1:0]        scl_meta;
  logic [1:0]        sda_meta;
  logic              scl_s;
  logic              sda_s;
  logic              scl_d;
  logic              sda_d;
  logic [1:0]        strap_meta;
  logic [1:0]        strap_s;
  logic [1:0]        addr_lo;
  logic              strap_taken;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;

  // Four flops per bus pin, two per strap pin; edge logic reads only the last two stages
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      scl_meta   <= 2'h3;
      sda_meta   <= 2'h3;
      strap_meta <= 2'h0;
      scl_s      <= 1'b1;
      sda_s      <= 1'b1;
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      strap_s    <= 2'h0;
    end else begin
      scl_meta   <= {scl_meta[0], i_scl};
      sda_meta   <= {sda_meta[0], i_sda};
      strap_meta <= i_addr_strap;
      scl_s      <= scl_meta[1];
      sda_s      <= sda_meta[1];
      scl_d      <= scl_s;
      sda_d      <= sda_s;
      strap_s    <= strap_meta;
    end
  end

  // strap latched once
  // Strap stage is read once, on the first edge after release, while it still holds its reset 00
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_lo     <= 2'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      addr_lo     <= strap_s;
      strap_taken <= 1'b1;
    end
  end

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Link domain: serial slave state machine
  // ----------------------------------------------------------------
  aicas_link_state_t state;
  aicas_link_state_t after_ack;
  logic [3:0]        bit_cnt;
  logic [7:0]        shift;
  logic [7:0]        tx;
  logic [7:0]        sub;
  logic              sda_low;
  logic              wr_en;
  logic [7:0]        wr_addr;
  logic [7:0]        wr_data;
  logic [7:0]        rd_data;
  logic [7:0]        page;
  logic [7:0]        book;
  logic [7:0]        mod_ctrl;
  logic [7:0]        pwr_ctrl;
  logic              base_page;
  logic              strap_match;

  assign base_page   = (page == PAGE_RESET) && (book == BOOK_RESET);
  assign strap_match = strap_taken && (shift[7:1] == {SLV_ADDR_HI, addr_lo});

  // byte engine
  // Start always restarts the frame, so repeated start needs no state
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      state     <= LS_IDLE;
      after_ack <= LS_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      tx        <= 8'h00;
      sub       <= 8'h00;
      sda_low   <= 1'b0;
      wr_en     <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_cond) begin
        state   <= LS_DEV;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (stop_cond) begin
        state   <= LS_IDLE;
        sda_low <= 1'b0;
      end else begin
        unique case (state)
          LS_IDLE: begin
            sda_low <= 1'b0;
          end
          LS_DEV, LS_REG, LS_WDATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == LS_DEV) begin
                if (strap_match) begin
                  sda_low   <= 1'b1;
                  state     <= LS_ACK;
                  after_ack <= shift[0] ? LS_RDATA : LS_REG;
                end else begin
                  state <= LS_IDLE;
                end
              end else if (state == LS_REG) begin
                sub       <= shift;
                sda_low   <= 1'b1;
                state     <= LS_ACK;
                after_ack <= LS_WDATA;
              end else begin
                wr_en     <= 1'b1;
                wr_addr   <= sub;
                wr_data   <= shift;
                sub       <= sub + 8'h01;
                sda_low   <= 1'b1;
                state     <= LS_ACK;
                after_ack <= LS_WDATA;
              end
            end
          end
          LS_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              state   <= after_ack;
              if (after_ack == LS_RDATA) begin
                tx      <= rd_data;
                sda_low <= ~rd_data[7];
                sub     <= sub + 8'h01;
              end else begin
                sda_low <= 1'b0;
              end
            end
          end
          LS_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_low <= 1'b0;
                state   <= LS_RACK;
              end else begin
                tx      <= {tx[6:0], 1'b0};
                sda_low <= ~tx[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          LS_RACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state <= LS_IDLE;
              end else begin
                state     <= LS_ACK;
                after_ack <= LS_RDATA;
              end
            end
          end
        endcase
      end
    end
  end

  // Open drain: the line is only ever pulled low
  assign o_sda    = 1'b0;
  assign o_sda_oe = sda_low;

  // ----------------------------------------------------------------
  // Link domain: register file
  // ----------------------------------------------------------------
  // Registers beyond the base page, except page select and book select on page zero, are not stored; their writes are
  // acknowledged and dropped so sequential bursts stay aligned.
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      page     <= PAGE_RESET;
      book     <= BOOK_RESET;
      mod_ctrl <= MOD_RESET;
      pwr_ctrl <= PWR_RESET;
    end else if (wr_en) begin
      if (wr_addr == REG_PAGE_SELECT) begin
        page <= wr_data;
      end
      if (wr_addr == REG_BOOK_SELECT && page == PAGE_RESET) begin
        book <= wr_data;
      end
      if (wr_addr == REG_MOD_CTRL && base_page) begin
        mod_ctrl <= wr_data;
      end
      if (wr_addr == REG_PWR_CTRL && base_page) begin
        pwr_ctrl <= wr_data;
      end
    end
  end

  // Read mux; unmapped locations return zero
  always_comb begin
    rd_data = 8'h00;
    if (sub == REG_PAGE_SELECT) begin
      rd_data = page;
    end else if (sub == REG_BOOK_SELECT && page == PAGE_RESET) begin
      rd_data = book;
    end else if (sub == REG_MOD_CTRL && base_page) begin
      rd_data = mod_ctrl;
    end else if (sub == REG_PWR_CTRL && base_page) begin
      rd_data = pwr_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Crossing of the control fields into the core domain
  // ----------------------------------------------------------------
  aicas_cross_if #(.W(XWORD_W)) xif ();

  assign xif.src_word = {mod_ctrl[FIELD_MSB:FIELD_LSB], pwr_ctrl[FIELD_MSB:FIELD_LSB]};

  aicas_word_sync #(
    .W (XWORD_W)
  ) u_sync (
    .i_src_clock (i_link_clock),
    .i_dst_clock (i_clock),
    .i_rst       (i_rst),
    .x           (xif.sync)
  );

  // ----------------------------------------------------------------
  // Core domain: power state outputs
  // ----------------------------------------------------------------
  logic [1:0]        pwr_code;
  logic [1:0]        mod_code;
  logic              playing;

  assign pwr_code = xif.dst_word[1:0];
  assign mod_code = xif.dst_word[3:2];
  assign playing  = (pwr_code == PWR_PLAY);

  // Registered so the supply enables never glitch on a word change
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_analog_supply_en <= 1'b0;
      o_gate_drive_en    <= 1'b0;
      o_output_hiz       <= 1'b1;
    end else begin
      o_analog_supply_en <= (pwr_code != PWR_DEEP_SLEEP);
      o_gate_drive_en    <= (pwr_code != PWR_DEEP_SLEEP);
      o_output_hiz       <= !playing;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: modulator
  // ----------------------------------------------------------------
  logic [7:0]        pwm_cnt;
  logic signed [7:0] level;
  logic [7:0]        half;
  logic [7:0]        mag;
  logic [7:0]        bd_pos;
  logic [7:0]        bd_neg;
  logic [7:0]        ss_rise;
  logic [7:0]        ss_fall;
  logic [7:0]        ss_pos;
  logic [7:0]        ss_neg;
  logic              use_single;
  logic [7:0]        next_pos_duty;
  logic [7:0]        next_neg_duty;

  // Free-running carrier shared by both legs keeps them in phase
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pwm_cnt <= 8'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  assign level = i_sample;
  assign half  = 8'(level >>> 1);
  assign mag   = level[7] ? 8'(-level) : 8'(level);

  assign bd_pos = MID_DUTY + half;
  assign bd_neg = MID_DUTY - half;

  assign ss_rise = SS_IDLE_DUTY + mag;
  assign ss_fall = (mag < SS_IDLE_DUTY) ? SS_IDLE_DUTY - mag : 8'h00;
  assign ss_pos  = level[7] ? ss_fall : ss_rise;
  assign ss_neg  = level[7] ? ss_rise : ss_fall;

  // Scheme choice per sample
  always_comb begin
    use_single = 1'b0;
    unique case (mod_code)
      MOD_SINGLE_SIDE: use_single = 1'b1;
      MOD_HYBRID:      use_single = (mag < {2'h0, i_supply_level[7:2]});
      default:         use_single = 1'b0;
    endcase
    next_pos_duty = use_single ? ss_pos : bd_pos;
    next_neg_duty = use_single ? ss_neg : bd_neg;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_positive_output_leg <= 1'b0;
      o_negative_output_leg <= 1'b0;
    end else begin
      o_positive_output_leg <= playing && (pwm_cnt < next_pos_duty);
      o_negative_output_leg <= playing && (pwm_cnt < next_neg_duty);
    end
  end

endmodule : aicas_top

//--- design/aicas_pkg.sv
package aicas_pkg;

  // ----------------------------------------------------------------
  // Slave address
  // ----------------------------------------------------------------
  localparam logic [4:0] SLV_ADDR_HI     = 5'h0B;  // Fixed upper address bits

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_PAGE_SELECT = 8'h00;
  localparam logic [7:0] REG_MOD_CTRL    = 8'h02;
  localparam logic [7:0] REG_PWR_CTRL    = 8'h03;
  localparam logic [7:0] REG_BOOK_SELECT = 8'h7F;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         FIELD_LSB       = 0;      // Two-bit fields at [1:0]
  localparam int         FIELD_MSB       = 1;
  localparam logic [7:0] PAGE_RESET      = 8'h00;
  localparam logic [7:0] BOOK_RESET      = 8'h00;
  localparam logic [7:0] MOD_RESET       = 8'h00;
  localparam logic [7:0] PWR_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PWR_DEEP_SLEEP  = 2'h0;
  localparam logic [1:0] PWR_SLEEP       = 2'h1;
  localparam logic [1:0] PWR_HIZ         = 2'h2;
  localparam logic [1:0] PWR_PLAY        = 2'h3;
  localparam logic [1:0] MOD_BOTH_SIDE   = 2'h0;
  localparam logic [1:0] MOD_SINGLE_SIDE = 2'h1;
  localparam logic [1:0] MOD_HYBRID      = 2'h2;

  // ----------------------------------------------------------------
  // Modulator constants
  // ----------------------------------------------------------------
  localparam logic [7:0] MID_DUTY        = 8'h80;  // 50 percent of 256
  localparam logic [7:0] SS_IDLE_DUTY    = 8'h24;  // About 14 percent of 256
  localparam int         XWORD_W         = 4;      // {modulation, power state}

  // Link-side protocol states
  typedef enum logic [2:0] {
    LS_IDLE, LS_DEV, LS_REG, LS_WDATA, LS_ACK, LS_RDATA, LS_RACK
  } aicas_link_state_t;

endpackage : aicas_pkg

//--- design/aicas_cross_if.sv
// Word crossing from the link domain into the core domain
interface aicas_cross_if #(
  parameter int W = 4
);
  logic [W-1:0] src_word;
  logic [W-1:0] dst_word;
  logic         dst_new;

  modport tx   (output src_word);
  modport rx   (input dst_word, input dst_new);
  modport sync (input src_word, output dst_word, output dst_new);
endinterface : aicas_cross_if

//--- design/aicas_word_sync.sv
// Toggle handshake: the held word stays still until the far side acks,
// so the destination may capture it without any bit skew.
module aicas_word_sync #(
  parameter int W = 4
) (
  input  wire logic    i_src_clock,
  input  wire logic    i_dst_clock,
  input  wire logic    i_rst,
  aicas_cross_if.sync  x
);
  logic [W-1:0] held;
  logic         req;
  logic         ack_meta;
  logic         ack_sync;
  logic         req_meta;
  logic         req_sync;
  logic         req_seen;
  logic [W-1:0] word;
  logic         word_new;

  // Source launches a new word only when the previous one was taken
  always_ff @(posedge i_src_clock or posedge i_rst) begin
    if (i_rst) begin
      held <= '0;
      req  <= 1'b0;
    end else if (req == ack_sync && x.src_word != held) begin
      held <= x.src_word;
      req  <= ~req;
    end
  end

  // Acknowledge back into the source domain
  always_ff @(posedge i_src_clock or posedge i_rst) begin
    if (i_rst) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= req_seen;
      ack_sync <= ack_meta;
    end
  end

  // Destination catches the toggle and samples the held word
  always_ff @(posedge i_dst_clock or posedge i_rst) begin
    if (i_rst) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
      word     <= '0;
      word_new <= 1'b0;
    end else begin
      req_meta <= req;
      req_sync <= req_meta;
      req_seen <= req_sync;
      word_new <= req_sync != req_seen;
      if (req_sync != req_seen) begin
        word <= held;
      end
    end
  end

  assign x.dst_word = word;
  assign x.dst_new  = word_new;

endmodule : aicas_word_sync

//--- bench/aicas_top_asserts.sv
// ----------------------------------------
// Port checker for the control port block
// ----------------------------------------
module aicas_top_asserts
  import aicas_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_link_clock,
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  input wire logic [1:0] i_addr_strap,
  input wire logic [7:0] i_sample,
  input wire logic [7:0] i_supply_level,
  input wire logic       o_analog_supply_en,
  input wire logic       o_gate_drive_en,
  input wire logic       o_output_hiz,
  input wire logic       o_positive_output_leg,
  input wire logic       o_negative_output_leg
);
  logic [3:0] zero_run;

  // Count play cycles with silent input; the leg pipeline needs a few to settle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      zero_run <= 4'h0;
    end else if (i_sample != 8'h00 || o_output_hiz) begin
      zero_run <= 4'h0;
    end else if (zero_run != 4'hF) begin
      zero_run <= zero_run + 4'h1;
    end
  end

  // A pulled bit holds for at least six link clocks, never a glitch
  sequence s_oe_rise;
    $rose(o_sda_oe);
  endsequence
  sequence s_oe_hold;
    o_sda_oe [*6];
  endsequence

  a_supply_gate_pair: assert property (@(posedge i_clock) disable iff (i_rst)
    o_analog_supply_en == o_gate_drive_en) else $error("supply and gate enables differ");
  a_sleep_means_hiz: assert property (@(posedge i_clock) disable iff (i_rst)
    !o_analog_supply_en |-> o_output_hiz) else $error("legs active without supply");
  a_hiz_legs_idle: assert property (@(posedge i_clock) disable iff (i_rst)
    o_output_hiz && $past(o_output_hiz) |-> !o_positive_output_leg && !o_negative_output_leg)
    else $error("leg switching in high impedance");
  a_play_switches: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(o_output_hiz) |-> ##[1:300] (o_positive_output_leg || o_negative_output_leg
    || o_output_hiz)) else $error("no switching in play");
  a_zero_in_phase: assert property (@(posedge i_clock) disable iff (i_rst)
    zero_run >= 4'h6 |-> o_positive_output_leg == o_negative_output_leg)
    else $error("legs out of phase at zero input");
  a_reset_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(i_rst) |-> o_output_hiz && !o_analog_supply_en && !o_sda_oe)
    else $error("outputs not quiet after reset");
  a_oe_ack_hold: assert property (@(posedge i_link_clock) disable iff (i_rst)
    s_oe_rise |-> s_oe_hold) else $error("data pull too short");
  a_oe_scl_low: assert property (@(posedge i_link_clock) disable iff (i_rst)
    $changed(o_sda_oe) |-> !i_scl) else $error("data pull moved while clock high");
endmodule : aicas_top_asserts

bind aicas_top aicas_top_asserts u_aicas_top_asserts (
  .i_clock(i_clock),
  .i_rst(i_rst),
  .i_link_clock(i_link_clock),
  .i_scl(i_scl),
  .i_sda(i_sda),
  .o_sda(o_sda),
  .o_sda_oe(o_sda_oe),
  .i_addr_strap(i_addr_strap),
  .i_sample(i_sample),
  .i_supply_level(i_supply_level),
  .o_analog_supply_en(o_analog_supply_en),
  .o_gate_drive_en(o_gate_drive_en),
  .o_output_hiz(o_output_hiz),
  .o_positive_output_leg(o_positive_output_leg),
  .o_negative_output_leg(o_negative_output_leg)
);

//--- bench/aicas_host_model.sv
// ----------------------------------------
// Host bus master on the two-wire port
// ----------------------------------------
module aicas_host_model (
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull,
  output logic      o_got,
  output logic[7:0] o_got_data
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 32;  // Bit time near 390 kHz, inside the fast rate

  // Clock stands high and data released outside frames
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
    o_got = 1'b0;
    o_got_data = 8'h00;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge i_clock);
  endtask : wt

  // Hand each ack or read byte to the bench monitor
  task automatic report(input logic [7:0] v);
    o_got_data = v;
    o_got = 1'b1;
    wt(1);
    o_got = 1'b0;
  endtask : report

  task automatic start_cond();
    wt(8);
    o_sda_pull = 1'b0;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_pull = 1'b1;
    wt(HALF);
    o_scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    wt(8);
    o_sda_pull = 1'b1;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_pull = 1'b0;
    wt(HALF);
  endtask : stop_cond

  // Data moves only well after the clock fall, so it never looks like a start
  task automatic bitx(input logic b, output logic s);
    wt(8);
    o_sda_pull = ~b;
    wt(HALF - 8);
    o_scl = 1'b1;
    wt(HALF / 2);
    s = i_sda;
    wt(HALF / 2);
    o_scl = 1'b0;
  endtask : bitx

  task automatic wbyte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(v[i], s);
    bitx(1'b1, s);
    report({7'h00, s});
  endtask : wbyte

  // master acks all but the last
  task automatic rbyte(input logic last);
    logic [7:0] v;
    logic       s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(last, s);
    report(v);
  endtask : rbyte

  task automatic write_regs(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d0,
                            input logic [7:0] d1, input bit two);
    start_cond();
    wbyte({dev, 1'b0});
    wbyte(r);
    wbyte(d0);
    if (two) wbyte(d1);
    stop_cond();
  endtask : write_regs

  // pointer write, repeated start, nack then stop
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] r, input bit two);
    start_cond();
    wbyte({dev, 1'b0});
    wbyte(r);
    start_cond();
    wbyte({dev, 1'b1});
    if (two) rbyte(1'b0);
    rbyte(1'b1);
    stop_cond();
  endtask : read_regs

  task automatic probe(input logic [6:0] dev);
    start_cond();
    wbyte({dev, 1'b0});
    stop_cond();
  endtask : probe
endmodule : aicas_host_model

//--- bench/aicas_top_tb.sv
// ----------------------------------------
// Self-checking bench for the control port
// ----------------------------------------
module aicas_top_tb
  import aicas_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clock = 1'b0;
  logic       i_link_clock = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_scl;
  logic       sda_wire;
  logic       o_sda;
  logic       o_sda_oe;
  logic       host_pull;
  logic       got;
  logic [7:0] got_data;
  logic [1:0] i_addr_strap;
  logic [7:0] i_sample;
  logic [7:0] i_supply_level;
  logic       sup;
  logic       gate;
  logic       hiz;
  logic [6:0] dev;
  logic [7:0] exp_q[$];
  logic [7:0] seq_r[8] = '{8'h00, 8'h7F, 8'h03, 8'h03, 8'h00, 8'h7F, 8'h03, 8'h03};
  logic [7:0] seq_d[8] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03};
  integer     seed;
  int         err_count = 0;
  int         n_tests = 0;
  int         cycles = 0;

  always #20 i_clock = ~i_clock;
  // Link clock offset so its edges drift against the core clock
  initial #17.3 forever #62.5 i_link_clock = ~i_link_clock;
  // Pull-up wins unless either side pulls low
  assign sda_wire = (o_sda_oe ? o_sda : 1'b1) & ~host_pull;

  aicas_top u_aicas_top (.i_clock(i_clock), .i_rst(i_rst), .i_link_clock(i_link_clock),
    .i_scl(i_scl), .i_sda(sda_wire), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_addr_strap(i_addr_strap), .i_sample(i_sample), .i_supply_level(i_supply_level),
    .o_analog_supply_en(sup), .o_gate_drive_en(gate), .o_output_hiz(hiz),
    .o_positive_output_leg(), .o_negative_output_leg());
  aicas_host_model u_aicas_host_model (.i_clock(i_clock), .i_sda(sda_wire), .o_scl(i_scl),
    .o_sda_pull(host_pull), .o_got(got), .o_got_data(got_data));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1, bit two);
    repeat (two ? 4 : 3) exp_q.push_back(8'h00);
    u_aicas_host_model.write_regs(dev, r, d0, d1, two);
  endtask : wr

  task automatic rd(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1, bit two);
    repeat (3) exp_q.push_back(8'h00);
    exp_q.push_back(e0);
    if (two) exp_q.push_back(e1);
    u_aicas_host_model.read_regs(dev, r, two);
  endtask : rd

  task automatic pwr(input logic [1:0] c);
    wr(REG_PWR_CTRL, {6'h00, c}, 8'h00, 1'b0);
    repeat (60) @(negedge i_clock);
    check({5'h00, sup, gate, hiz}, {5'h00, c != 2'h0, c != 2'h0, c != 2'h3});
  endtask : pwr

  // Silent input first, then random levels while the legs switch
  task automatic play_samples();
    i_sample = 8'h00;
    repeat (300) @(negedge i_clock);
    repeat (300) begin
      @(negedge i_clock);
      i_sample = 8'($random(seed));
    end
  endtask : play_samples

  // Oldest note against each result the host reports
  always @(posedge i_clock) begin
    if (got === 1'b1) check(got_data, exp_q.size() > 0 ? exp_q.pop_front() : ~got_data);
  end

  // Cut a hang short
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 95000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    seed = 28267;
    i_addr_strap = 2'($random(seed));
    i_supply_level = 8'($random(seed));
    i_sample = 8'h00;
    dev = {SLV_ADDR_HI, i_addr_strap};
    repeat (8) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (20) @(negedge i_clock);
    check({5'h00, sup, gate, hiz}, 8'h01);
    exp_q.push_back(8'h01);
    u_aicas_host_model.probe({SLV_ADDR_HI, ~i_addr_strap});
    for (int k = 0; k < 8; k++) begin
      if (seq_r[k] == REG_PWR_CTRL) pwr(seq_d[k][1:0]);
      else wr(seq_r[k], seq_d[k], 8'h00, 1'b0);
    end
    pwr(PWR_SLEEP);
    pwr(PWR_PLAY);
    wr(REG_MOD_CTRL, {6'h00, MOD_SINGLE_SIDE}, {6'h00, PWR_PLAY}, 1'b1);
    rd(REG_MOD_CTRL, {6'h00, MOD_SINGLE_SIDE}, {6'h00, PWR_PLAY}, 1'b1);
    play_samples();
    pwr(PWR_HIZ);
    wr(REG_MOD_CTRL, {6'h00, MOD_HYBRID}, 8'h00, 1'b0);
    pwr(PWR_PLAY);
    play_samples();
    wr(REG_MOD_CTRL, 8'h00, 8'h00, 1'b0);
    rd(REG_MOD_CTRL, 8'h00, 8'h00, 1'b0);
    play_samples();
    // top page value, control registers hidden there
    wr(REG_PAGE_SELECT, 8'hFF, 8'h00, 1'b0);
    rd(REG_PAGE_SELECT, 8'hFF, 8'h00, 1'b0);
    rd(REG_PWR_CTRL, 8'h00, 8'h00, 1'b0);
    wr(REG_PAGE_SELECT, 8'h00, 8'h00, 1'b0);
    wr(REG_BOOK_SELECT, 8'h01, 8'h00, 1'b0);
    rd(REG_PWR_CTRL, 8'h00, 8'h00, 1'b0);
    wr(REG_BOOK_SELECT, 8'h00, 8'h00, 1'b0);
    rd(REG_PWR_CTRL, {6'h00, PWR_PLAY}, 8'h00, 1'b0);
    repeat (10) @(negedge i_clock);
    check(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule : aicas_top_tb
